/* rtl/aom_mode_ctrl.sv */
// operating mode control with ahb-lite register slave
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module aom_mode_ctrl #(
	parameter int BASE_CYC = aom_pkg::BASE_CYC,
	parameter int FIRST_CYC = aom_pkg::FIRST_EXTRA_CYC,
	parameter int SETTLE_CYC = aom_pkg::SETTLE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [13:0] acc_x,
	input wire logic [13:0] acc_y,
	input wire logic [13:0] acc_z,
	input wire logic [13:0] temp_data,
	input wire logic [13:0] adc_data,
	input wire logic act_detect,
	output logic act_single_sample,
	output logic afe_power,
	output logic temp_power,
	output logic adc_power,
	output logic quiet_sensing_option,
	output logic [1:0] range_sel,
	output logic fifo_push,
	output logic fifo_temp_en,
	output logic int_out,
	output logic wake_out
);
	typedef struct packed {
		aom_pkg::aom_state_e st;
		logic [31:0] ctrl;
		logic [31:0] cnt;
		logic busy;
		logic [31:0] settle;
		logic act_flag;
		logic drdy;
		logic combo_err;
		logic [13:0] x;
		logic [13:0] y;
		logic [13:0] z;
		logic [13:0] t;
		logic [13:0] a;
		logic conv_start;
		logic fifo_push;
		logic ph_wr;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
	} aom_ctl_s;

	localparam aom_ctl_s RST = '0;

	aom_ctl_s r_reg;
	aom_ctl_s r_next;

	// only three modes exist; the spare code falls back to standby
	function automatic aom_pkg::aom_state_e to_state(input logic [1:0] code);
		aom_pkg::aom_state_e s;
		s = aom_pkg::ST_STBY;
		if (code == aom_pkg::MODE_MEAS) begin
			s = aom_pkg::ST_MEAS;
		end else if (code == aom_pkg::MODE_WAKE) begin
			s = aom_pkg::ST_WAKE;
		end
		return s;
	endfunction

	function automatic logic [1:0] st_code(input aom_pkg::aom_state_e s);
		logic [1:0] c;
		c = aom_pkg::MODE_STBY;
		if (s == aom_pkg::ST_MEAS) begin
			c = aom_pkg::MODE_MEAS;
		end else if (s == aom_pkg::ST_WAKE) begin
			c = aom_pkg::MODE_WAKE;
		end
		return c;
	endfunction

	// cycles to the next sample boundary, minus one for the down counter
	function automatic logic [31:0] period(input aom_pkg::aom_state_e s, input logic [31:0] c);
		logic [2:0] odr;
		logic [31:0] p;
		odr = c[aom_pkg::C_ODR +: 3];
		if (odr > aom_pkg::ODR_MAX_CODE) begin
			odr = aom_pkg::ODR_MAX_CODE;
		end
		if (s == aom_pkg::ST_WAKE) begin
			p = 32'(BASE_CYC) << (aom_pkg::WAKE_SHIFT + {3'h0, c[aom_pkg::C_WRATE +: 2]});
		end else begin
			p = 32'(BASE_CYC) << (aom_pkg::ODR_MAX_CODE - odr);
		end
		return p - 32'h0000_0001;
	endfunction

	function automatic logic [31:0] rd(input aom_ctl_s s, input logic [7:0] addr);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (addr)
			aom_pkg::REG_CTRL: d = s.ctrl;
			aom_pkg::REG_STATUS: begin
				d[1:0] = st_code(s.st);
				d[aom_pkg::S_ACT] = s.act_flag;
				d[aom_pkg::S_DRDY] = s.drdy;
				d[aom_pkg::S_SETTLED] = (s.st == aom_pkg::ST_MEAS) && (s.settle == 32'h0);
				d[aom_pkg::S_COMBO] = s.combo_err;
			end
			aom_pkg::REG_ACC_XY: d = {2'h0, s.y, 2'h0, s.x};
			aom_pkg::REG_ACC_ZT: d = {2'h0, s.t, 2'h0, s.z};
			aom_pkg::REG_ADC: d = {18'h0, s.a};
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	logic acc;
	logic tick;
	logic auto_go;
	aom_pkg::aom_state_e req;

	always_comb begin
		r_next = r_reg;
		r_next.conv_start = 1'b0;
		r_next.fifo_push = 1'b0;
		acc = hsel && hready && htrans[1];
		tick = (r_reg.st != aom_pkg::ST_STBY) && (r_reg.cnt == 32'h0);
		auto_go = 1'b0;
		// data phase of a write; status bits clear by writing one
		if (r_reg.ph_wr) begin
			if (r_reg.ph_addr == aom_pkg::REG_CTRL) begin
				r_next.ctrl = hwdata;
				if (hwdata[aom_pkg::C_MODE +: 2] == aom_pkg::MODE_WAKE && hwdata[aom_pkg::C_QUIET]) begin
					// refused: the pair is not supported, fall back to standby
					r_next.ctrl[aom_pkg::C_MODE +: 2] = aom_pkg::MODE_STBY;
					r_next.combo_err = 1'b1;
				end
			end else if (r_reg.ph_addr == aom_pkg::REG_STATUS) begin
				if (hwdata[aom_pkg::S_ACT]) begin
					r_next.act_flag = 1'b0;
				end
				if (hwdata[aom_pkg::S_DRDY]) begin
					r_next.drdy = 1'b0;
				end
				if (hwdata[aom_pkg::S_COMBO]) begin
					r_next.combo_err = 1'b0;
				end
			end
		end
		req = to_state(r_next.ctrl[aom_pkg::C_MODE +: 2]);
		if (r_reg.settle != 32'h0) begin
			r_next.settle = r_reg.settle - 32'h0000_0001;
		end
		unique case (r_reg.st)
			aom_pkg::ST_STBY: begin
				// nothing is sampled here, so a new mode starts at once
				if (req != aom_pkg::ST_STBY) begin
					r_next.st = req;
					r_next.cnt = period(req, r_next.ctrl);
					if (req == aom_pkg::ST_WAKE) begin
						r_next.cnt = r_next.cnt + 32'(FIRST_CYC);
					end else begin
						r_next.settle = 32'(SETTLE_CYC);
					end
				end
			end
			aom_pkg::ST_MEAS, aom_pkg::ST_WAKE: begin
				if (req == aom_pkg::ST_STBY) begin
					r_next.st = aom_pkg::ST_STBY;
					r_next.busy = 1'b0;
				end else if (tick) begin
					r_next.conv_start = 1'b1;
					r_next.busy = 1'b1;
					r_next.st = req;
					r_next.cnt = period(req, r_next.ctrl);
					if (req == aom_pkg::ST_MEAS && r_reg.st != aom_pkg::ST_MEAS) begin
						r_next.settle = 32'(SETTLE_CYC);
					end
				end else begin
					r_next.cnt = r_reg.cnt - 32'h0000_0001;
				end
			end
		endcase
		// one result set per boundary keeps all enabled channels in step
		if (conv_done && r_reg.busy && req != aom_pkg::ST_STBY && r_reg.st != aom_pkg::ST_STBY) begin
			r_next.busy = 1'b0;
			r_next.x = acc_x;
			r_next.y = acc_y;
			r_next.z = acc_z;
			if (r_reg.ctrl[aom_pkg::C_TEMP]) begin
				r_next.t = temp_data;
			end
			if (r_reg.ctrl[aom_pkg::C_ADC]) begin
				r_next.a = adc_data;
			end
			r_next.drdy = 1'b1;
			r_next.fifo_push = 1'b1;
			if (act_detect) begin
				r_next.act_flag = 1'b1;
				auto_go = (r_reg.st == aom_pkg::ST_WAKE) && r_reg.ctrl[aom_pkg::C_AUTO];
			end
		end
		// without activity wake-up simply keeps its own cadence
		if (auto_go) begin
			r_next.st = aom_pkg::ST_MEAS;
			r_next.ctrl[aom_pkg::C_MODE +: 2] = aom_pkg::MODE_MEAS;
			r_next.cnt = period(aom_pkg::ST_MEAS, r_next.ctrl);
			r_next.settle = 32'(SETTLE_CYC);
		end
		r_next.ph_wr = acc && hwrite;
		if (acc) begin
			r_next.ph_addr = haddr[7:0];
			if (!hwrite) begin
				r_next.rdata = rd(r_next, haddr[7:0]);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign hrdata = r_reg.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign conv_start = r_reg.conv_start;
	assign fifo_push = r_reg.fifo_push;
	assign fifo_temp_en = r_reg.ctrl[aom_pkg::C_TFIFO] && r_reg.ctrl[aom_pkg::C_TEMP];
	// sensing electronics always powered in measure, in wake-up only around a sample
	assign afe_power = (r_reg.st == aom_pkg::ST_MEAS) || (r_reg.st == aom_pkg::ST_WAKE && r_reg.busy);
	assign temp_power = afe_power && r_reg.ctrl[aom_pkg::C_TEMP];
	assign adc_power = afe_power && r_reg.ctrl[aom_pkg::C_ADC];
	assign quiet_sensing_option = r_reg.ctrl[aom_pkg::C_QUIET] && (r_reg.st == aom_pkg::ST_MEAS);
	assign range_sel = r_reg.ctrl[aom_pkg::C_RANGE +: 2];
	assign act_single_sample = (r_reg.st == aom_pkg::ST_WAKE);
	assign int_out = r_reg.act_flag && r_reg.ctrl[aom_pkg::C_INT];
	assign wake_out = r_reg.act_flag && r_reg.ctrl[aom_pkg::C_WAKE];

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_stby_no_sample: assert property (r_reg.st == aom_pkg::ST_STBY |=> !conv_start)
		else $error("sample started from standby");
	chk_stby_flag_kept: assert property ((r_reg.st == aom_pkg::ST_STBY && !r_reg.ph_wr) |=> $stable(r_reg.act_flag))
		else $error("flag changed in standby");
	chk_wake_power_off: assert property ((r_reg.st == aom_pkg::ST_WAKE && !r_reg.busy) |-> !afe_power)
		else $error("electronics powered between wake samples");
	chk_no_quiet_wake: assert property (r_reg.st == aom_pkg::ST_WAKE |-> !quiet_sensing_option)
		else $error("quiet option active in wake-up");
	chk_auto_measure: assert property ((r_reg.st == aom_pkg::ST_WAKE && r_reg.busy && conv_done && act_detect
		&& r_reg.ctrl[aom_pkg::C_AUTO] && r_reg.ctrl[1:0] == aom_pkg::MODE_WAKE && !r_reg.ph_wr)
		|=> r_reg.st == aom_pkg::ST_MEAS)
		else $error("no switch to measure on activity");
	chk_stop_standby: assert property ((r_reg.st != aom_pkg::ST_STBY && r_reg.ph_wr
		&& r_reg.ph_addr == aom_pkg::REG_CTRL && hwdata[aom_pkg::C_MODE +: 2] == aom_pkg::MODE_STBY)
		|=> r_reg.st == aom_pkg::ST_STBY ##1 !conv_start [*2])
		else $error("sampling continued after standby");
	chk_sync_capture: assert property ((conv_done && r_reg.busy && r_reg.st != aom_pkg::ST_STBY
		&& r_reg.ctrl[aom_pkg::C_TEMP] && r_reg.ctrl[1:0] != aom_pkg::MODE_STBY && !r_reg.ph_wr)
		|=> r_reg.t == $past(temp_data) && r_reg.x == $past(acc_x) && fifo_push)
		else $error("temperature not captured with acceleration");
	chk_adc_off: assert property (!r_reg.ctrl[aom_pkg::C_ADC] |-> !adc_power)
		else $error("converter powered while disabled");
	chk_boundary_hold: assert property ((r_reg.st == aom_pkg::ST_MEAS && r_reg.cnt != 32'h0 && !conv_done
		&& r_reg.ctrl[1:0] == aom_pkg::MODE_WAKE && !r_reg.ph_wr) |=> r_reg.st == aom_pkg::ST_MEAS)
		else $error("mode changed between boundaries");

	// standby freezes results as well as flags
	chk_stby_data_kept: assert property (r_reg.st == aom_pkg::ST_STBY
		|=> $stable(r_reg.x) && !fifo_push)
		else $error("data changed in standby");

	chk_temp_hold: assert property (!r_reg.ctrl[aom_pkg::C_TEMP]
		|=> $stable(r_reg.t))
		else $error("temperature updated while disabled");

	chk_adc_hold: assert property (!r_reg.ctrl[aom_pkg::C_ADC]
		|=> $stable(r_reg.a))
		else $error("converter result updated while off");

	chk_start_single: assert property (conv_start
		|=> !conv_start)
		else $error("sample start longer than one cycle");

	chk_start_power: assert property (conv_start
		|-> afe_power)
		else $error("sample started unpowered");

	chk_meas_power: assert property (r_reg.st == aom_pkg::ST_MEAS
		|-> afe_power)
		else $error("measure mode unpowered");

	chk_quiet_meas: assert property (quiet_sensing_option
		|-> r_reg.st == aom_pkg::ST_MEAS)
		else $error("quiet option outside measure");

	chk_single_sample: assert property (r_reg.st == aom_pkg::ST_WAKE
		|-> act_single_sample)
		else $error("multi-sample detection in wake-up");

	chk_tfifo_temp: assert property (fifo_temp_en
		|-> r_reg.ctrl[aom_pkg::C_TEMP])
		else $error("temperature queued while disabled");

	// a refused pair must leave the block idle and say so
	chk_combo_refused: assert property ((r_reg.ph_wr && r_reg.ph_addr == aom_pkg::REG_CTRL && !conv_done
		&& hwdata[aom_pkg::C_MODE +: 2] == aom_pkg::MODE_WAKE && hwdata[aom_pkg::C_QUIET])
		|=> r_reg.ctrl[1:0] == aom_pkg::MODE_STBY && r_reg.combo_err)
		else $error("wake-up with quiet option accepted");

	chk_first_late: assert property ((r_reg.st == aom_pkg::ST_STBY && r_reg.ph_wr
		&& r_reg.ph_addr == aom_pkg::REG_CTRL && hwdata[1:0] == aom_pkg::MODE_WAKE && !hwdata[aom_pkg::C_QUIET])
		|=> r_reg.st == aom_pkg::ST_WAKE && r_reg.cnt >= 32'(FIRST_CYC))
		else $error("first wake-up interval not lengthened");

	chk_settle_start: assert property ((r_reg.st == aom_pkg::ST_STBY && r_reg.ph_wr
		&& r_reg.ph_addr == aom_pkg::REG_CTRL && hwdata[1:0] == aom_pkg::MODE_MEAS)
		|=> r_reg.st == aom_pkg::ST_MEAS && r_reg.settle == 32'(SETTLE_CYC))
		else $error("settle time not started");

	chk_wake_stays: assert property ((r_reg.st == aom_pkg::ST_WAKE && r_reg.ctrl[1:0] == aom_pkg::MODE_WAKE
		&& !r_reg.ph_wr && !(conv_done && act_detect))
		|=> r_reg.st == aom_pkg::ST_WAKE)
		else $error("left wake-up without activity");

	chk_auto_ctrl: assert property ((r_reg.st == aom_pkg::ST_WAKE && r_reg.busy && conv_done && act_detect
		&& r_reg.ctrl[aom_pkg::C_AUTO] && r_reg.ctrl[1:0] == aom_pkg::MODE_WAKE && !r_reg.ph_wr)
		|=> r_reg.ctrl[1:0] == aom_pkg::MODE_MEAS && r_reg.settle == 32'(SETTLE_CYC))
		else $error("auto switch left mode field stale");

	chk_act_outputs: assert property ((conv_done && r_reg.busy && act_detect && r_reg.st != aom_pkg::ST_STBY
		&& r_reg.ctrl[1:0] != aom_pkg::MODE_STBY && r_reg.ctrl[aom_pkg::C_INT] && r_reg.ctrl[aom_pkg::C_WAKE]
		&& !r_reg.ph_wr) |=> int_out && wake_out)
		else $error("activity not signalled");

	chk_fifo_follows: assert property ((conv_done && r_reg.busy && r_reg.st != aom_pkg::ST_STBY
		&& r_reg.ctrl[1:0] != aom_pkg::MODE_STBY && !r_reg.ph_wr)
		|=> fifo_push && r_reg.drdy)
		else $error("sample set not pushed");
endmodule

/* inc/aom_pkg.sv */
// constants for the accelerometer operating mode control block
package aom_pkg;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ACC_XY = 8'h08;
	localparam logic [7:0] REG_ACC_ZT = 8'h0c;
	localparam logic [7:0] REG_ADC = 8'h10;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int C_MODE = 0;
	localparam int C_QUIET = 2;
	localparam int C_AUTO = 3;
	localparam int C_WRATE = 4;
	localparam int C_ODR = 6;
	localparam int C_RANGE = 9;
	localparam int C_TEMP = 11;
	localparam int C_ADC = 12;
	localparam int C_TFIFO = 13;
	localparam int C_INT = 14;
	localparam int C_WAKE = 15;
	localparam int S_ACT = 2;
	localparam int S_DRDY = 3;
	localparam int S_SETTLED = 4;
	localparam int S_COMBO = 5;
	localparam logic [1:0] MODE_STBY = 2'h0;
	localparam logic [1:0] MODE_MEAS = 2'h1;
	localparam logic [1:0] MODE_WAKE = 2'h2;
	localparam logic [2:0] ODR_MAX_CODE = 3'h5;
	localparam logic [4:0] WAKE_SHIFT = 5'h05;
	localparam int CLK_HZ = 40_000_000;
	localparam int ODR_MAX_HZ = 400;
	localparam int FIRST_EXTRA_MS = 10;
	localparam int SETTLE_MS = 100;
	localparam int BASE_CYC = CLK_HZ / ODR_MAX_HZ;
	localparam int FIRST_EXTRA_CYC = CLK_HZ / 1000 * FIRST_EXTRA_MS;
	localparam int SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
	typedef enum logic [1:0] {ST_STBY, ST_MEAS, ST_WAKE} aom_state_e;
endpackage

/* sim/aom_sense_model.sv */
// sensing front end model answering conversion requests
`timescale 1ns/1ps
module aom_sense_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic conv_start,
	input wire logic slow,
	input wire logic act_req,
	input wire logic [13:0] val,
	output logic conv_done,
	output logic act_detect,
	output logic [13:0] acc_x,
	output logic [13:0] acc_y,
	output logic [13:0] acc_z,
	output logic [13:0] temp_data,
	output logic [13:0] adc_data
);
	int cnt;
	logic [13:0] pat;
	// lines churn outside the done cycle, so a stale latch never matches
	assign acc_x = conv_done ? val : pat;
	assign acc_y = conv_done ? val ^ 14'h0001 : ~pat;
	assign acc_z = conv_done ? val ^ 14'h0002 : pat ^ 14'h2aaa;
	assign temp_data = conv_done ? val ^ 14'h0003 : pat ^ 14'h1555;
	assign adc_data = conv_done ? val ^ 14'h0004 : ~pat ^ 14'h0f0f;
	assign act_detect = conv_done & act_req; // one-sample decision
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			conv_done <= 1'b0;
			pat <= 14'h0;
		end else begin
			pat <= pat + 14'h1357;
			conv_done <= 1'b0;
			if (conv_start) begin
				cnt <= slow ? 5 : 1;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
				conv_done <= (cnt == 1); // one answer per request
			end
		end
	end
endmodule

/* sim/accel_operating_mode_control_bench.sv */
// self-checking bench for the operating mode control block
`timescale 1ns/1ps
module accel_operating_mode_control_bench;
	localparam int BASE = 8;
	localparam int FIRST = 5;
	logic hclk, hresetn, hsel, hwrite, dph_rd, slow, act_req;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, range_sel;
	logic [2:0] hsize;
	logic hreadyout, hresp, conv_start, conv_done, act_detect, act_single_sample, afe_power, temp_power;
	logic adc_power, quiet_sensing_option, fifo_push, fifo_temp_en, int_out, wake_out;
	logic [13:0] ax, ay, az, td, ad, val;
	logic [63:0] expq[$];
	int miscompares, checks, seed, n, starts, pushes, s0, p0;
	aom_mode_ctrl #(.BASE_CYC(BASE), .FIRST_CYC(FIRST), .SETTLE_CYC(20)) u_aom_mode_ctrl (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.conv_start(conv_start), .conv_done(conv_done), .acc_x(ax), .acc_y(ay), .acc_z(az), .temp_data(td),
		.adc_data(ad), .act_detect(act_detect), .act_single_sample(act_single_sample), .afe_power(afe_power),
		.temp_power(temp_power), .adc_power(adc_power), .quiet_sensing_option(quiet_sensing_option),
		.range_sel(range_sel), .fifo_push(fifo_push), .fifo_temp_en(fifo_temp_en), .int_out(int_out),
		.wake_out(wake_out));
	aom_sense_model u_aom_sense_model (.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start), .slow(slow),
		.act_req(act_req), .val(val), .conv_done(conv_done), .act_detect(act_detect), .acc_x(ax), .acc_y(ay),
		.acc_z(az), .temp_data(td), .adc_data(ad));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// the master waits on hready itself; no fixed latency is assumed
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		k = 0;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		dph_rd <= !w;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		dph_rd <= 1'b0;
		if (k >= 50) begin miscompares++; summarize(); end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		expq.push_back({m, e});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic wstart(output int c);
		c = 0;
		do begin @(posedge hclk); #1; c++; end while (conv_start !== 1'b1 && c < 5000);
		if (c >= 5000) begin miscompares++; summarize(); end
	endtask
	task automatic pause(input int c);
		repeat (c) @(posedge hclk);
		#1;
	endtask
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (conv_start === 1'b1) starts++;
		if (fifo_push === 1'b1) pushes++;
		if (dph_rd === 1'b1 && hreadyout === 1'b1) begin
			chk("hrdata", hrdata & expq[0][63:32], expq[0][31:0]);
			void'(expq.pop_front());
		end
	end
	initial begin
		pause(100000);
		miscompares++;
		summarize();
	end
	initial begin
		{hresetn, hsel, hwrite, dph_rd, slow, act_req} = 6'h0;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		seed = 32'h1b14;
		val = 14'($random(seed));
		pause(4);
		hresetn <= 1'b1;
		rd(aom_pkg::REG_CTRL, 32'hffff_ffff, aom_pkg::CTRL_RESET);
		rd(aom_pkg::REG_STATUS, 32'hffff_ffff, 32'h0);
		rd(8'h20, 32'hffff_ffff, 32'h0);
		chk("afe", 32'(afe_power), 32'h1 ^ 32'h1);
		// standby config: measure, quiet, odr 400, range 2, temp, adc, temp in fifo
		xfer(1'b1, aom_pkg::REG_CTRL, 32'h0000_3d45);
		pause(2);
		chk("quiet", 32'(quiet_sensing_option), 32'h1);
		chk("range", 32'(range_sel), 32'h2);
		chk("tfifo", 32'(fifo_temp_en), 32'h1);
		chk("pwr", {afe_power, temp_power, adc_power}, 32'h7);
		slow <= 1'b1;
		wstart(n);
		wstart(n);
		chk("period", n, BASE);
		pause(24);
		rd(aom_pkg::REG_STATUS, 32'h3f, 32'h19);
		xfer(1'b1, aom_pkg::REG_CTRL, 32'h0000_3d44);
		pause(2);
		s0 = starts;
		p0 = pushes;
		rd(aom_pkg::REG_ACC_XY, 32'hffff_ffff, {2'h0, val ^ 14'h1, 2'h0, val});
		rd(aom_pkg::REG_ACC_ZT, 32'hffff_ffff, {4'h0, val ^ 14'h3, 2'h0, val ^ 14'h2});
		rd(aom_pkg::REG_ADC, 32'hffff_ffff, {18'h0, val ^ 14'h4});
		pause(40);
		chk("idle", starts - s0 + pushes - p0, 32'h0);
		chk("afe", 32'(afe_power), 32'h0);
		xfer(1'b1, aom_pkg::REG_CTRL, 32'h0000_0006);
		rd(aom_pkg::REG_CTRL, 32'hffff_ffff, 32'h4);
		rd(aom_pkg::REG_STATUS, 32'h2f, 32'h28);
		xfer(1'b1, aom_pkg::REG_STATUS, 32'h28);
		rd(aom_pkg::REG_STATUS, 32'h2f, 32'h0);
		for (int r = 0; r < 4; r++) begin
			xfer(1'b1, aom_pkg::REG_CTRL, 32'h802 | (r << 4));
			pause(2);
			chk("single", {act_single_sample, quiet_sensing_option}, 32'h2);
			wstart(n);
			chk("first", 32'(n >= (BASE << (5 + r)) && n <= (BASE << (5 + r)) + FIRST + 2), 32'h1);
			chk("afe on", 32'(afe_power), 32'h1);
			wstart(n);
			chk("wperiod", n, BASE << (5 + r));
			pause(20);
			chk("afe off", 32'(afe_power), 32'h0);
			rd(aom_pkg::REG_STATUS, 32'h3, 32'h2);
			xfer(1'b1, aom_pkg::REG_CTRL, 32'h0);
		end
		slow <= 1'b0;
		act_req <= 1'b1;
		xfer(1'b1, aom_pkg::REG_CTRL, 32'h0000_c00a);
		wstart(n);
		pause(4);
		chk("irq", {int_out, wake_out}, 32'h3);
		rd(aom_pkg::REG_CTRL, 32'h3, 32'h1);
		rd(aom_pkg::REG_STATUS, 32'h7, 32'h5);
		act_req <= 1'b0;
		xfer(1'b1, aom_pkg::REG_CTRL, 32'h0000_c00a);
		rd(aom_pkg::REG_STATUS, 32'h3, 32'h1);
		wstart(n);
		pause(2);
		rd(aom_pkg::REG_STATUS, 32'h3, 32'h2);
		xfer(1'b1, aom_pkg::REG_CTRL, 32'h0000_c008);
		pause(2);
		chk("kept", 32'(int_out), 32'h1);
		xfer(1'b1, aom_pkg::REG_STATUS, 32'h4);
		pause(2);
		chk("clear", 32'(int_out), 32'h0);
		xfer(1'b1, aom_pkg::REG_CTRL, 32'h0000_0941);
		pause(2);
		chk("adc off", {afe_power, temp_power, adc_power}, 32'h6);
		xfer(1'b1, aom_pkg::REG_CTRL, 32'h0);
		pause(4);
		summarize();
	end
endmodule
